// >>> include/icd_pkg.sv
// icd_pkg: command codes, address bases and field layout for the bus command decoder.
// assumes bytes are already taken in by an acceptor handshake and given here on low-true lines.
package icd_pkg;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  localparam logic [6:0] LISTEN_BASE = 7'h20;
  localparam logic [6:0] TALK_BASE = 7'h40;
  localparam logic [1:0] GROUP_CMD = 2'h0;
  localparam logic [1:0] GROUP_LISTEN = 2'h1;
  localparam logic [1:0] GROUP_TALK = 2'h2;
  localparam logic [1:0] GROUP_SECONDARY = 2'h3;
  localparam int GROUP_MSB = 6;
  localparam int GROUP_LSB = 5;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic RESET_FALSE = 1'b0;
endpackage : icd_pkg

// >>> include/icd_stream_if.sv
// icd_stream_if: valid/ready byte stream with end flag between decoder and its fifo.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface icd_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : icd_stream_if
`default_nettype wire

// >>> verilog/icd_fifo.sv
// icd_fifo: synchronous fifo with registered read data and valid/ready on both sides.
// assumes depth is a power of two; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module icd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  icd_stream_if.sink wr,
  input wire logic i_rd_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("icd_fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;
  assign full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty = (wptr_reg == rptr_reg);
  assign wr.ready = !full;
  assign do_wr = wr.valid && !full;
  // output stage is a register: refill it when empty or being taken
  assign do_rd = !empty && (!o_rd_valid || i_rd_ready);
  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wptr_reg <= '0;
    end else if (do_wr) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rptr_reg <= '0;
    end else if (do_rd) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else if (do_rd) begin
      o_rd_valid <= 1'b1;
      o_rd_data <= mem[rptr_reg[AW-1:0]];
    end else if (i_rd_ready) begin
      o_rd_valid <= 1'b0;
    end
  end
endmodule : icd_fifo
`default_nettype wire

// >>> verilog/icd_decoder.sv
// icd_decoder: device-side interpreter of bus uniline lines and attention-qualified bytes.
// assumes bus pins arrive active low and synchronous; an acceptor delivers each byte as a
// one-cycle strobe with the attention and end levels sampled alongside it.
`timescale 1ns/1ps
`default_nettype none
module icd_decoder #(
  parameter int ADDR_W = icd_pkg::ADDR_W,
  parameter int DATA_W = icd_pkg::DATA_W,
  parameter int FIFO_DEPTH = icd_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_atn_n,
  input wire logic i_ifc_n,
  input wire logic i_ren_n,
  input wire logic i_eoi_n,
  input wire logic i_byte_strobe,
  input wire logic [DATA_W-1:0] i_dio_n,
  input wire logic [ADDR_W-1:0] i_primary_addr,
  input wire logic i_cfg_ren_lockout,
  input wire logic i_service_needed,
  input wire logic i_service_done,
  input wire logic i_data_ready,
  output logic o_data_valid,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_end,
  output logic o_remote,
  output logic o_lockout,
  output logic o_panel_locked,
  output logic o_listener,
  output logic o_talker,
  output logic o_serial_poll,
  output logic o_device_clear,
  output logic o_trigger,
  output logic o_srq_n_out,
  output logic o_srq_oe,
  output logic o_data_overflow
);
  // code and address decode below is fixed to seven-bit codes on an eight-bit bus
  if (ADDR_W != 5 || DATA_W != 8) begin : g_width_check
    $error("icd_decoder serves five-bit addresses on an eight-bit bus only");
  end

  typedef enum logic [1:0] {
    ICD_IDLE,
    ICD_ADDRESSED,
    ICD_ACTIVE
  } icd_role_type;

  // bus lines are low-true; convert once here
  logic atn;
  logic ifc;
  logic ren;
  logic eoi;
  logic [DATA_W-1:0] dio;
  assign atn = !i_atn_n;
  assign ifc = !i_ifc_n;
  assign ren = !i_ren_n;
  assign eoi = !i_eoi_n;
  assign dio = ~i_dio_n;

  logic [6:0] code;
  logic [1:0] group;
  logic cmd_strobe;
  logic data_strobe;
  assign code = dio[6:0];
  assign group = code[icd_pkg::GROUP_MSB:icd_pkg::GROUP_LSB];
  // the strobe stands for a byte already taken by the acceptor interlock outside
  assign cmd_strobe = i_byte_strobe && atn;
  assign data_strobe = i_byte_strobe && !atn;

  // primary address 31 gives a listen address equal to unlisten; unlisten wins, so
  // that address can never be listened on
  logic [6:0] my_listen;
  logic [6:0] my_talk;
  assign my_listen = icd_pkg::LISTEN_BASE | {2'h0, i_primary_addr};
  assign my_talk = icd_pkg::TALK_BASE | {2'h0, i_primary_addr};

  icd_role_type listen_reg;
  icd_role_type talk_reg;
  logic listening;
  assign listening = (listen_reg != ICD_IDLE);

  logic is_unl;
  logic is_unt;
  logic is_my_listen;
  logic is_my_talk;
  logic is_other_talk;
  assign is_unl = cmd_strobe && code == icd_pkg::CMD_UNL;
  assign is_unt = cmd_strobe && code == icd_pkg::CMD_UNT;
  assign is_my_listen = cmd_strobe && group == icd_pkg::GROUP_LISTEN && code == my_listen;
  assign is_my_talk = cmd_strobe && group == icd_pkg::GROUP_TALK && code == my_talk;
  // a different talk address unaddresses us as talker (only one talker on the bus)
  assign is_other_talk = cmd_strobe && group == icd_pkg::GROUP_TALK && !is_unt && !is_my_talk;

  logic cmd_group;
  logic do_llo;
  logic do_dcl;
  logic do_spe;
  logic do_spd;
  logic do_sdc;
  logic do_gtl;
  logic do_get;
  logic clear_event;
  assign cmd_group = cmd_strobe && group == icd_pkg::GROUP_CMD;
  // anything else in the command group (parallel poll, take control) falls through unused
  assign do_llo = cmd_group && code == icd_pkg::CMD_LLO;
  assign do_dcl = cmd_group && code == icd_pkg::CMD_DCL;
  assign do_spe = cmd_group && code == icd_pkg::CMD_SPE;
  assign do_spd = cmd_group && code == icd_pkg::CMD_SPD;
  assign do_sdc = cmd_group && listening && code == icd_pkg::CMD_SDC;
  assign do_gtl = cmd_group && listening && code == icd_pkg::CMD_GTL;
  // trigger kept strictly addressed, so a broadcast to other devices leaves us idle
  assign do_get = cmd_group && listening && code == icd_pkg::CMD_GET;
  assign clear_event = do_dcl || do_sdc;
  // secondary group bytes match no decode term, so they alter no state below

  // listener and talker outputs move with their state on the edge that takes the byte,
  // like the other state outputs, so a command may follow its address back to back
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || ifc) begin
      listen_reg <= ICD_IDLE;
      o_listener <= icd_pkg::RESET_FALSE;
    end else if (is_unl) begin
      listen_reg <= ICD_IDLE;
      o_listener <= 1'b0;
    end else if (is_my_listen) begin
      listen_reg <= ICD_ADDRESSED;
      o_listener <= 1'b1;
    end else begin
      case (listen_reg)
        ICD_ADDRESSED: begin
          if (data_strobe) begin
            listen_reg <= ICD_ACTIVE;
          end
        end
        ICD_ACTIVE: begin
          if (atn) begin
            listen_reg <= ICD_ADDRESSED;
          end
        end
        ICD_IDLE: begin
          o_listener <= 1'b0;
        end
        default: begin
          // unused encoding: fall back to idle rather than hang
          listen_reg <= ICD_IDLE;
          o_listener <= 1'b0;
        end
      endcase
    end
  end

  // talker: addressed by own talk address, active once attention drops
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || ifc) begin
      talk_reg <= ICD_IDLE;
      o_talker <= icd_pkg::RESET_FALSE;
    end else if (is_unt || is_other_talk) begin
      talk_reg <= ICD_IDLE;
      o_talker <= 1'b0;
    end else if (is_my_talk) begin
      talk_reg <= ICD_ADDRESSED;
      o_talker <= 1'b1;
    end else begin
      case (talk_reg)
        ICD_ADDRESSED: begin
          if (!atn) begin
            talk_reg <= ICD_ACTIVE;
          end
        end
        ICD_ACTIVE: begin
          if (atn) begin
            talk_reg <= ICD_ADDRESSED;
          end
        end
        ICD_IDLE: begin
          o_talker <= 1'b0;
        end
        default: begin
          talk_reg <= ICD_IDLE;
          o_talker <= 1'b0;
        end
      endcase
    end
  end

  // remote needs remote enable and is set by own listen address; go-to-local drops it until the controller re-addresses
  logic remote_next;
  always_comb begin
    remote_next = o_remote;
    if (!ren) begin
      remote_next = 1'b0;
    end else if (do_gtl) begin
      remote_next = 1'b0;
    end else if (is_my_listen) begin
      remote_next = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_remote <= icd_pkg::RESET_FALSE;
    end else begin
      o_remote <= remote_next;
    end
  end

  // lockout survives device clear; only remote enable false or go-to-local lifts it
  logic lockout_next;
  always_comb begin
    lockout_next = o_lockout;
    if (!ren || do_gtl) begin
      lockout_next = 1'b0;
    end else if (do_llo) begin
      lockout_next = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_lockout <= icd_pkg::RESET_FALSE;
    end else begin
      o_lockout <= lockout_next;
    end
  end

  // panel lock follows the next lockout and remote values so it moves with them
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_panel_locked <= icd_pkg::RESET_FALSE;
    end else begin
      o_panel_locked <= lockout_next || (remote_next && i_cfg_ren_lockout);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn || ifc) begin
      o_serial_poll <= icd_pkg::RESET_FALSE;
    end else if (do_spd) begin
      o_serial_poll <= 1'b0;
    end else if (do_spe) begin
      o_serial_poll <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_device_clear <= icd_pkg::RESET_FALSE;
      o_trigger <= icd_pkg::RESET_FALSE;
    end else begin
      o_device_clear <= clear_event;
      o_trigger <= do_get;
    end
  end

  // service request: a pending need is held until the device says it was handled or a device clear comes;
  // a new need in the same cycle as done wins so no request is lost
  logic srq_pend_reg;
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      srq_pend_reg <= icd_pkg::RESET_FALSE;
    end else if (i_service_needed) begin
      srq_pend_reg <= 1'b1;
    end else if (i_service_done || clear_event) begin
      srq_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_srq_oe <= icd_pkg::RESET_FALSE;
      o_srq_n_out <= 1'b1;
    end else begin
      // open drain: pull low while pending, else release
      o_srq_oe <= srq_pend_reg || i_service_needed;
      o_srq_n_out <= 1'b0;
    end
  end

  // data bytes with their end flag go through the fifo; when full the byte is counted
  // lost, since an acceptor holding off is outside this block
  icd_stream_if #(.WIDTH(DATA_W + 1)) wr_if ();
  assign wr_if.valid = data_strobe && listening;
  assign wr_if.data = {eoi, dio};

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_data_overflow <= icd_pkg::RESET_FALSE;
    end else if (wr_if.valid && !wr_if.ready) begin
      o_data_overflow <= 1'b1;
    end else if (clear_event) begin
      o_data_overflow <= 1'b0;
    end
  end

  // fifo read side pops whenever the output register is free or being taken
  logic [DATA_W:0] rd_word;
  logic rd_valid;
  icd_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .wr(wr_if.sink),
    .i_rd_ready(i_data_ready || !o_data_valid),
    .o_rd_valid(rd_valid),
    .o_rd_data(rd_word)
  );

  // output skid register keeps the top outputs on flip-flops
  logic take_out;
  assign take_out = !o_data_valid || i_data_ready;
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_data_valid <= icd_pkg::RESET_FALSE;
      o_data <= '0;
      o_data_end <= icd_pkg::RESET_FALSE;
    end else if (take_out) begin
      o_data_valid <= rd_valid;
      o_data <= rd_word[DATA_W-1:0];
      o_data_end <= rd_word[DATA_W] && rd_valid;
    end
  end
endmodule : icd_decoder
`default_nettype wire

// >>> tb/icd_ctrl_model.sv
// icd_ctrl_model: bus controller model driving the uniline lines and strobed bytes.
// assumes the decoder samples all lines at the rising edge of i_mclk.
`timescale 1ns/1ps
`default_nettype none
module icd_ctrl_model (
  input wire logic i_mclk,
  output logic o_atn_n,
  output logic o_ifc_n,
  output logic o_ren_n,
  output logic o_eoi_n,
  output logic o_strobe,
  output logic [7:0] o_dio_n
);
  initial begin
    o_atn_n = 1'b1;
    o_ifc_n = 1'b1;
    o_ren_n = 1'b1;
    o_eoi_n = 1'b1;
    o_strobe = 1'b0;
    o_dio_n = 8'hFF;
  end
  // one byte in true logic; the lines carry it inverted
  task send(input logic atn, input logic [7:0] b, input logic last);
    @(posedge i_mclk);
    o_atn_n <= ~atn;
    o_dio_n <= ~b;
    o_eoi_n <= ~last;
    o_strobe <= 1'b1;
    @(posedge i_mclk);
    o_strobe <= 1'b0;
    // released lines float back to their pull-ups and read as false
    o_dio_n <= 8'hFF;
    o_eoi_n <= 1'b1;
    #1;
  endtask : send
  task lines(input logic ifc, input logic ren);
    @(posedge i_mclk);
    o_ifc_n <= ~ifc;
    o_ren_n <= ~ren;
    @(posedge i_mclk);
    #1;
  endtask : lines
endmodule : icd_ctrl_model
`default_nettype wire

// >>> tb/icd_decoder_properties.sv
// icd_decoder_properties: port-level checks of the command decoder.
// assumes it is bound into icd_decoder; bytes decode in the cycle after their strobe.
`timescale 1ns/1ps
`default_nettype none
module icd_decoder_properties #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_atn_n,
  input wire logic i_ifc_n,
  input wire logic i_ren_n,
  input wire logic i_byte_strobe,
  input wire logic [DATA_W-1:0] i_dio_n,
  input wire logic [ADDR_W-1:0] i_primary_addr,
  input wire logic i_service_needed,
  input wire logic i_data_ready,
  input wire logic o_data_valid,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_remote,
  input wire logic o_lockout,
  input wire logic o_listener,
  input wire logic o_talker,
  input wire logic o_serial_poll,
  input wire logic o_device_clear,
  input wire logic o_trigger,
  input wire logic o_srq_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic [6:0] cmd;
  logic atb;
  logic [6:0] own_l;
  logic [6:0] own_t;
  assign cmd = ~i_dio_n[6:0];
  assign atb = i_byte_strobe && !i_atn_n && i_ifc_n;
  assign own_l = icd_pkg::LISTEN_BASE | 7'(i_primary_addr);
  assign own_t = icd_pkg::TALK_BASE | 7'(i_primary_addr);
  property p_lsn; atb && cmd == own_l |=> o_listener; endproperty
  a_lsn: assert property (p_lsn) else $error("listen address missed");
  property p_tlk; atb && cmd == own_t |=> o_talker; endproperty
  a_tlk: assert property (p_tlk) else $error("talk address missed");
  property p_unl; atb && cmd == icd_pkg::CMD_UNL |=> !o_listener; endproperty
  a_unl: assert property (p_unl) else $error("unlisten ignored");
  property p_unt; atb && cmd == icd_pkg::CMD_UNT |=> !o_talker; endproperty
  a_unt: assert property (p_unt) else $error("untalk ignored");
  property p_llo; atb && cmd == icd_pkg::CMD_LLO && !i_ren_n |=> o_lockout; endproperty
  a_llo: assert property (p_llo) else $error("lockout not set");
  property p_dcl; atb && cmd == icd_pkg::CMD_DCL |=> o_device_clear; endproperty
  a_dcl: assert property (p_dcl) else $error("device clear missed");
  property p_spe; atb && cmd == icd_pkg::CMD_SPE |=> o_serial_poll; endproperty
  a_spe: assert property (p_spe) else $error("poll not entered");
  property p_spd; atb && cmd == icd_pkg::CMD_SPD |=> !o_serial_poll; endproperty
  a_spd: assert property (p_spd) else $error("poll not left");
  property p_sdc; atb && cmd == icd_pkg::CMD_SDC |=> o_device_clear == $past(o_listener); endproperty
  a_sdc: assert property (p_sdc) else $error("selective clear wrong");
  property p_get; atb && cmd == icd_pkg::CMD_GET && o_listener |=> o_trigger; endproperty
  a_get: assert property (p_get) else $error("trigger missed");
  property p_gtl; atb && cmd == icd_pkg::CMD_GTL && o_listener |=> !o_remote && !o_lockout; endproperty
  a_gtl: assert property (p_gtl) else $error("go to local ignored");
  property p_ifc; !i_ifc_n |=> !o_listener && !o_talker && !o_serial_poll; endproperty
  a_ifc: assert property (p_ifc) else $error("interface clear ignored");
  property p_ren; i_ren_n |=> !o_remote && !o_lockout; endproperty
  a_ren: assert property (p_ren) else $error("remote without enable");
  property p_scg;
    atb && cmd[6:5] == icd_pkg::GROUP_SECONDARY |=> $stable(o_listener) && $stable(o_talker);
  endproperty
  a_scg: assert property (p_scg) else $error("secondary byte acted on");
  property p_dat;
    i_byte_strobe && i_atn_n && i_ifc_n |=> $stable(o_listener) && $stable(o_serial_poll);
  endproperty
  a_dat: assert property (p_dat) else $error("data byte decoded");
  property p_hold; o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data); endproperty
  a_hold: assert property (p_hold) else $error("data not held");
  property p_srq; i_service_needed |=> o_srq_oe; endproperty
  a_srq: assert property (p_srq) else $error("service request late");
endmodule : icd_decoder_properties
bind icd_decoder icd_decoder_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_icd_decoder_properties (
  .i_mclk, .i_resetn, .i_atn_n, .i_ifc_n, .i_ren_n, .i_byte_strobe, .i_dio_n, .i_primary_addr,
  .i_service_needed, .i_data_ready, .o_data_valid, .o_data, .o_remote, .o_lockout, .o_listener,
  .o_talker, .o_serial_poll, .o_device_clear, .o_trigger, .o_srq_oe);
`default_nettype wire

// >>> tb/ieee488_command_decoder_bench.sv
// ieee488_command_decoder_bench: drives command sequences and checks decoder state outputs.
// assumes icd_ctrl_model stands in for the bus controller.
`timescale 1ns/1ps
`default_nettype none
module ieee488_command_decoder_bench;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_atn_n, i_ifc_n, i_ren_n, i_eoi_n, i_byte_strobe;
  logic [7:0] i_dio_n;
  logic [4:0] i_primary_addr = 5'h18;
  logic i_cfg_ren_lockout = 1'b1;
  logic i_service_needed = 1'b0;
  logic i_service_done = 1'b0;
  logic i_data_ready = 1'b0;
  logic o_data_valid, o_data_end, o_remote, o_lockout, o_panel_locked, o_listener, o_talker;
  logic o_serial_poll, o_device_clear, o_trigger, o_srq_n_out, o_srq_oe, o_data_overflow;
  logic [7:0] o_data;
  logic [7:0] nop [5] = '{8'h65, 8'h7F, 8'h05, 8'h15, 8'h09};
  logic [7:0] txt [4] = '{8'h2A, 8'h52, 8'h53, 8'h54};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 i_mclk = ~i_mclk;
  icd_ctrl_model u_icd_ctrl_model (.i_mclk, .o_atn_n(i_atn_n), .o_ifc_n(i_ifc_n),
    .o_ren_n(i_ren_n), .o_eoi_n(i_eoi_n), .o_strobe(i_byte_strobe), .o_dio_n(i_dio_n));
  icd_decoder u_icd_decoder (.i_mclk, .i_resetn, .i_atn_n, .i_ifc_n, .i_ren_n, .i_eoi_n,
    .i_byte_strobe, .i_dio_n, .i_primary_addr, .i_cfg_ren_lockout, .i_service_needed,
    .i_service_done, .i_data_ready, .o_data_valid, .o_data, .o_data_end, .o_remote, .o_lockout,
    .o_panel_locked, .o_listener, .o_talker, .o_serial_poll, .o_device_clear, .o_trigger,
    .o_srq_n_out, .o_srq_oe, .o_data_overflow);
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task cmd(input logic [7:0] b);
    u_icd_ctrl_model.send(1'b1, b, 1'b0);
  endtask : cmd
  // the consumer stalls until a byte shows, then takes it with one ready cycle
  task rd(input logic [7:0] e, input logic last);
    int n;
    n = 0;
    while (o_data_valid !== 1'b1 && n < 50) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk(o_data_valid, 1'b1);
    chk(o_data, e);
    chk(o_data_end, last);
    @(posedge i_mclk) i_data_ready <= 1'b1;
    @(posedge i_mclk) i_data_ready <= 1'b0;
    #1;
  endtask : rd
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("Error %0t: run did not finish", $time);
      print_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    #1;
    chk({o_listener, o_talker, o_remote, o_lockout, o_data_valid}, 8'h00);
    u_icd_ctrl_model.lines(1'b0, 1'b1);
    cmd(8'h3F);
    cmd(8'h38);
    chk({o_listener, o_remote, o_panel_locked}, 8'h07);
    cmd(8'h04);
    chk(o_device_clear, 1'b1);
    cmd(8'h08);
    chk(o_trigger, 1'b1);
    for (int i = 0; i < 4; i++) u_icd_ctrl_model.send(1'b0, txt[i], i == 3);
    chk(o_listener, 1'b1);
    for (int i = 0; i < 4; i++) rd(txt[i], i == 3);
    for (int i = 0; i < 40; i++) u_icd_ctrl_model.send(1'b0, 8'(i), 1'b0);
    chk(o_data_overflow, 1'b1);
    for (int i = 0; i < 34; i++) rd(8'(i), 1'b0);
    repeat (4) @(posedge i_mclk);
    #1;
    chk(o_data_valid, 1'b0);
    cmd(8'h3F);
    chk(o_listener, 1'b0);
    cmd(8'h04);
    chk(o_device_clear, 1'b0);
    cmd(8'h08);
    chk(o_trigger, 1'b0);
    cmd(8'h14);
    chk(o_device_clear, 1'b1);
    @(posedge i_mclk);
    #1;
    chk(o_data_overflow, 1'b0);
    cmd(8'h11);
    chk(o_lockout, 1'b1);
    cmd(8'h38);
    cmd(8'h01);
    chk({o_remote, o_lockout}, 8'h00);
    cmd(8'h18);
    chk(o_serial_poll, 1'b1);
    cmd(8'h19);
    chk(o_serial_poll, 1'b0);
    cmd(8'h58);
    chk(o_talker, 1'b1);
    for (int i = 0; i < 5; i++) begin
      cmd(nop[i]);
      chk({o_listener, o_talker}, 8'h03);
    end
    cmd(8'h5F);
    chk(o_talker, 1'b0);
    cmd(8'h18);
    u_icd_ctrl_model.lines(1'b1, 1'b1);
    chk({o_listener, o_serial_poll}, 8'h00);
    u_icd_ctrl_model.lines(1'b0, 1'b1);
    cmd(8'h38);
    chk(o_remote, 1'b1);
    chk(o_panel_locked, 1'b1);
    @(posedge i_mclk) i_cfg_ren_lockout <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk(o_panel_locked, 1'b0);
    cmd(8'h11);
    chk({o_lockout, o_panel_locked}, 8'h03);
    u_icd_ctrl_model.lines(1'b0, 1'b0);
    chk({o_remote, o_lockout, o_panel_locked}, 8'h00);
    @(posedge i_mclk) i_service_needed <= 1'b1;
    @(posedge i_mclk) i_service_needed <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk({o_srq_oe, o_srq_n_out}, 8'h02);
    @(posedge i_mclk) i_service_done <= 1'b1;
    @(posedge i_mclk) i_service_done <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk(o_srq_oe, 1'b0);
    print_verdict;
  end
endmodule : ieee488_command_decoder_bench
`default_nettype wire
